// ===== pmt_pkg.sv
// package: register map, field layout and reset values of the period match timer
package pmt_pkg;
    // register byte offsets (word aligned)
    localparam logic [7:0] PMT_OFF_COUNT = 8'h00;
    localparam logic [7:0] PMT_OFF_PERIOD = 8'h04;
    localparam logic [7:0] PMT_OFF_CONTROL = 8'h08;
    localparam logic [7:0] PMT_OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] PMT_OFF_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] PMT_OFF_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] PMT_OFF_IRQ_PRIORITY = 8'h18;
    // control field positions
    localparam int PMT_CTL_PRE_LSB = 0;
    localparam int PMT_CTL_RUN_BIT = 2;
    localparam int PMT_CTL_POST_LSB = 3;
    localparam logic [7:0] PMT_CTL_MASK = 8'h7F;
    // status bit of the match event
    localparam int PMT_IRQ_MATCH_BIT = 1;
    localparam logic [7:0] PMT_IRQ_MASK = 8'h02;
    // reset values
    localparam logic [7:0] PMT_RST_COUNT = 8'h00;
    localparam logic [7:0] PMT_RST_PERIOD = 8'hFF;
    localparam logic [7:0] PMT_RST_CONTROL = 8'h00;
    localparam logic [7:0] PMT_RST_IRQ = 8'h00;
    // prescale ratios, as terminal counts
    localparam logic [3:0] PMT_PRE_DIV1_LAST = 4'h0;
    localparam logic [3:0] PMT_PRE_DIV4_LAST = 4'h3;
    localparam logic [3:0] PMT_PRE_DIV16_LAST = 4'hF;
    // bus responses
    localparam logic [1:0] PMT_RESP_OKAY = 2'h0;
    localparam logic [1:0] PMT_RESP_SLVERR = 2'h2;
endpackage

// ===== pmt_prescaler.sv
// file: input prescaler producing a one-cycle tick at 1, 4 or 16 cycles
module pmt_prescaler
    import pmt_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic run,
    input wire logic [1:0] select,
    output logic tick
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [3:0] last;

    // -------------------------------------------------------------
    // ratio decode
    // -------------------------------------------------------------
    // 1x means divide by 16 regardless of bit 0
    assign last = select[1] ? PMT_PRE_DIV16_LAST :
                  (select[0] ? PMT_PRE_DIV4_LAST : PMT_PRE_DIV1_LAST);
    assign tick = run && !clear && (cnt_r >= last);
    assign cnt_nxt = tick ? 4'h0 : cnt_r + 4'h1;

    // count only while running; clear wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
        end else if (clear) begin
            cnt_r <= 4'h0;
        end else if (run) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ===== pmt_timer.sv
// file: period match timer with axi4-lite register slave and interrupt
//
// Summary of operation
// - count rises from zero to the period value, then wraps to zero.
// - reset loads the period register with all ones.
// - prescaler divides core clock by 1, 4 or 16 from a 2-bit field.
// - postscaler field n counts n+1 matches per flag event.
// - postscaler terminal count sets the sticky match flag.
// - count or control writes and reset clear prescaler and postscaler.
// - a control write leaves the count value unchanged.
// - count resets to zero and is readable and writable.
// - control bit 2 runs the timer when set, stops it when clear.
// - period is writable any time; new value used for later matches.
// - raw match pulse before postscaler goes to the serial port.
// - count and match pulse are exported as the pwm time base.
// - control bit 7 reads zero and ignores writes.
module pmt_timer
    import pmt_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic irq_priority,
    output logic sync_serial_port_shift_tick,
    output logic [7:0] pwm_time_base_count,
    output logic pwm_time_base_match
);
    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [7:0] period_timer_count_r;
    logic [7:0] period_compare_value_r;
    logic [7:0] period_timer_control_r;
    logic [7:0] peripheral_irq_flags_one_r;
    logic [7:0] peripheral_irq_enables_one_r;
    logic [7:0] peripheral_irq_priority_one_r;
    logic [3:0] post_cnt_r;
    logic [7:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic w_have_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // -------------------------------------------------------------
    // write channel: address and data in either order
    // -------------------------------------------------------------
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_byte0;
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic wr_enable;
    logic wr_clear;
    logic wr_prio;
    logic wr_mapped;
    logic wstrb_lane0;

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign wr_addr = aw_have_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_have_r ? w_data_r : s_axi_wdata;
    // fires in the cycle both halves are present
    assign wr_fire = !bvalid_r
                     && (aw_have_r || s_axi_awvalid)
                     && (w_have_r || s_axi_wvalid);
    // only byte lane 0 carries register data
    assign wr_byte0 = wr_fire && wstrb_lane0;
    assign wr_count = wr_byte0 && (wr_addr == PMT_OFF_COUNT);
    assign wr_period = wr_byte0 && (wr_addr == PMT_OFF_PERIOD);
    assign wr_control = wr_byte0 && (wr_addr == PMT_OFF_CONTROL);
    assign wr_enable = wr_byte0 && (wr_addr == PMT_OFF_IRQ_ENABLE);
    assign wr_clear = wr_byte0 && (wr_addr == PMT_OFF_IRQ_CLEAR);
    assign wr_prio = wr_byte0 && (wr_addr == PMT_OFF_IRQ_PRIORITY);
    assign wr_mapped = is_mapped(wr_addr);

    // strobe of lane 0, held or live; a named wire, not a function
    // without arguments, so a change of the held strobe is seen
    logic [3:0] w_strb_r;
    assign wstrb_lane0 = w_have_r ? w_strb_r[0] : s_axi_wstrb[0];

    // address decode shared by reads and writes
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == PMT_OFF_COUNT) || (a == PMT_OFF_PERIOD)
            || (a == PMT_OFF_CONTROL) || (a == PMT_OFF_IRQ_STATUS)
            || (a == PMT_OFF_IRQ_ENABLE) || (a == PMT_OFF_IRQ_CLEAR)
            || (a == PMT_OFF_IRQ_PRIORITY);
    endfunction

    // hold whichever half arrives first
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    // write response, unmapped addresses answer slverr
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= PMT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? PMT_RESP_OKAY : PMT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // -------------------------------------------------------------
    // timer core
    // -------------------------------------------------------------
    logic run;
    logic pre_tick;
    logic scaler_clear;
    logic match;
    logic post_done;
    logic [7:0] count_nxt;

    assign run = period_timer_control_r[PMT_CTL_RUN_BIT];
    assign scaler_clear = wr_count || wr_control;
    // match is the increment at which count equals period
    assign match = pre_tick && (period_timer_count_r
                                == period_compare_value_r);
    assign post_done = match && (post_cnt_r == period_timer_control_r[6:3]);
    assign count_nxt = match ? 8'h00 : period_timer_count_r + 8'h01;

    pmt_prescaler u_pre (
        .core_clk(core_clk),
        .rst(rst),
        .clear(scaler_clear),
        .run(run),
        .select(period_timer_control_r[1:0]),
        .tick(pre_tick)
    );

    // count: software write wins, control write leaves it alone
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            period_timer_count_r <= PMT_RST_COUNT;
        end else if (wr_count) begin
            period_timer_count_r <= wr_data[7:0];
        end else if (pre_tick) begin
            period_timer_count_r <= count_nxt;
        end
    end

    // postscaler counts matches; clears with the prescaler
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            post_cnt_r <= 4'h0;
        end else if (scaler_clear) begin
            post_cnt_r <= 4'h0;
        end else if (match) begin
            post_cnt_r <= post_done ? 4'h0 : post_cnt_r + 4'h1;
        end
    end

    // period and control registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            period_compare_value_r <= PMT_RST_PERIOD;
            period_timer_control_r <= PMT_RST_CONTROL;
        end else begin
            if (wr_period) begin
                period_compare_value_r <= wr_data[7:0];
            end
            if (wr_control) begin
                // bit 7 not implemented
                period_timer_control_r <= wr_data[7:0] & PMT_CTL_MASK;
            end
        end
    end

    // -------------------------------------------------------------
    // interrupt: sticky flag, set beats clear
    // -------------------------------------------------------------
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    assign flag_set = post_done ? PMT_IRQ_MASK : 8'h00;
    assign flag_clr = wr_clear ? (wr_data[7:0] & PMT_IRQ_MASK) : 8'h00;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            peripheral_irq_flags_one_r <= PMT_RST_IRQ;
            peripheral_irq_enables_one_r <= PMT_RST_IRQ;
            peripheral_irq_priority_one_r <= PMT_RST_IRQ;
        end else begin
            peripheral_irq_flags_one_r <= (peripheral_irq_flags_one_r
                & ~flag_clr) | flag_set;
            if (wr_enable) begin
                peripheral_irq_enables_one_r <= wr_data[7:0] & PMT_IRQ_MASK;
            end
            if (wr_prio) begin
                peripheral_irq_priority_one_r <= wr_data[7:0] & PMT_IRQ_MASK;
            end
        end
    end
    assign irq = |(peripheral_irq_flags_one_r & peripheral_irq_enables_one_r);
    assign irq_priority = peripheral_irq_priority_one_r[PMT_IRQ_MATCH_BIT];

    // exported match pulses and count for the serial port and pwm units
    assign sync_serial_port_shift_tick = match;
    assign pwm_time_base_match = match;
    assign pwm_time_base_count = period_timer_count_r;

    // -------------------------------------------------------------
    // read channel
    // -------------------------------------------------------------
    logic [7:0] rd_byte;
    assign s_axi_arready = !rvalid_r;
    // clear register is write-only and reads zero
    assign rd_byte =
        (s_axi_araddr == PMT_OFF_COUNT) ? period_timer_count_r :
        (s_axi_araddr == PMT_OFF_PERIOD) ? period_compare_value_r :
        (s_axi_araddr == PMT_OFF_CONTROL) ? period_timer_control_r :
        (s_axi_araddr == PMT_OFF_IRQ_STATUS) ? peripheral_irq_flags_one_r :
        (s_axi_araddr == PMT_OFF_IRQ_ENABLE) ? peripheral_irq_enables_one_r :
        (s_axi_araddr == PMT_OFF_IRQ_PRIORITY) ?
            peripheral_irq_priority_one_r : 8'h00;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= PMT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= is_mapped(s_axi_araddr) ? PMT_RESP_OKAY
                                               : PMT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_count_wrap: assert property (
        match && !wr_count |=> period_timer_count_r == 8'h00)
        else $error("count did not wrap after match");
    a_count_step: assert property (
        pre_tick && !match && !wr_count |=>
            period_timer_count_r == $past(period_timer_count_r) + 8'h01)
        else $error("count did not step on tick");
    a_count_hold: assert property (
        !run && !wr_count |=> $stable(period_timer_count_r))
        else $error("count moved while stopped");
    a_ctl_keeps_count: assert property (
        wr_control && !pre_tick && !wr_count |=>
            $stable(period_timer_count_r))
        else $error("control write changed count");
    // with divide by 1 the first tick follows the clear at once
    a_scaler_clear: assert property (
        scaler_clear |=> post_cnt_r == 4'h0
            && (!pre_tick || period_timer_control_r[1:0] == 2'b00))
        else $error("scalers not cleared on write");
    a_count_load: assert property (
        wr_count |=> period_timer_count_r == $past(wr_data[7:0]))
        else $error("count write not taken");
    a_period_load: assert property (
        wr_period |=> period_compare_value_r == $past(wr_data[7:0]))
        else $error("period write not taken");
    a_flag_set: assert property (
        post_done |=> peripheral_irq_flags_one_r[PMT_IRQ_MATCH_BIT])
        else $error("flag not set at postscaler end");
    a_post_ratio: assert property (
        match && !post_done && !scaler_clear |=>
            post_cnt_r == $past(post_cnt_r) + 4'h1)
        else $error("postscaler did not count match");
    a_post_wrap: assert property (
        post_done && !scaler_clear |=> post_cnt_r == 4'h0)
        else $error("postscaler did not restart");
    // the flag may only fall on a software clear
    a_flag_sticky: assert property (
        peripheral_irq_flags_one_r[1] && !flag_clr[1]
            |=> peripheral_irq_flags_one_r[1])
        else $error("match flag dropped without clear");
    a_bit7_zero: assert property (
        period_timer_control_r[7] == 1'b0)
        else $error("control bit 7 set");
    // a control write may retune the prescaler mid-count; allow for it
    a_pre_div16: assert property (
        pre_tick && period_timer_control_r[1] && !scaler_clear
            |=> (!pre_tick || !period_timer_control_r[1])[*8])
        else $error("divide by 16 ticked too soon");
    a_pre_div4: assert property (
        pre_tick && period_timer_control_r[1:0] == 2'b01 && !scaler_clear
            |=> (!pre_tick || period_timer_control_r[1:0] == 2'b00)[*3])
        else $error("divide by 4 ticked too soon");
    a_irq_level: assert property (
        peripheral_irq_flags_one_r[1] && peripheral_irq_enables_one_r[1]
            |-> irq)
        else $error("irq low with enabled flag");

    c_wrap: cover property (match);
    c_flag: cover property (post_done);
    c_wr_resp: cover property (s_axi_bvalid && s_axi_bready);
    c_rd_resp: cover property (s_axi_rvalid && s_axi_rready);
    c_div16: cover property (pre_tick && period_timer_control_r[1]);
endmodule

// ===== pmt_testbench.sv
// file: self-checking testbench of the period match timer
module testbench
    import pmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // clock, reset and design signals
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, irq_priority, shift_tick, match;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] count;
    int fails = 0;
    int comparisons = 0;

    always #12.5 core_clk = ~core_clk;

    pmt_timer i_dut (
        .core_clk(core_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq), .irq_priority(irq_priority),
        .sync_serial_port_shift_tick(shift_tick),
        .pwm_time_base_count(count), .pwm_time_base_match(match)
    );

    // ----------------------------------------------------------------
    // shared helpers; every bus task is entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic timed_out();
        fails++;
        end_of_test();
    endtask

    // handshakes and answers are taken at the rising edge itself
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        logic got;
        int n;
        n = 0;
        got = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!got) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            got = s_axi_bvalid;
            r = s_axi_bresp;
            if (++n > 50) timed_out();
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic got;
        int n;
        n = 0;
        got = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!got) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            got = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (++n > 50) timed_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_write(a, {24'h0, d}, r);
        check(r, PMT_RESP_OKAY);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(r, PMT_RESP_OKAY);
        check(d, {24'h0, exp});
    endtask

    // cycles until the next match pulse, counted at falling edges
    task automatic wait_match(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (match !== 1'b1 && n < 400);
        if (n >= 400) timed_out();
    endtask

    function automatic logic [7:0] ctl(input int post, input int run,
                                       input int pre);
        return 8'((post << PMT_CTL_POST_LSB) | (run << PMT_CTL_RUN_BIT) | pre);
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        rd_check(PMT_OFF_COUNT, 8'h00);
        rd_check(PMT_OFF_PERIOD, 8'hFF);
        rd_check(PMT_OFF_CONTROL, 8'h00);
        rd_check(PMT_OFF_IRQ_STATUS, 8'h00);
        rd_check(PMT_OFF_IRQ_ENABLE, 8'h00);
        rd_check(PMT_OFF_IRQ_PRIORITY, 8'h00);
    endtask

    // unmapped place and write-only clear register
    task automatic t_bus_edges();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(8'h1C, 32'h0000_00FF, r);
        check(r, PMT_RESP_SLVERR);
        axi_read(8'h1C, d, r);
        check(r, PMT_RESP_SLVERR);
        check(d, 32'h0);
        rd_check(PMT_OFF_IRQ_CLEAR, 8'h00);
        wr(PMT_OFF_IRQ_PRIORITY, 8'h02);
        check(irq_priority, 1'b1);
        rd_check(PMT_OFF_IRQ_PRIORITY, 8'h02);
        wr(PMT_OFF_CONTROL, 8'hFB); // run bit off, every other bit set
        rd_check(PMT_OFF_CONTROL, 8'h7B);
    endtask

    // wrap point and match spacing for every prescale code
    task automatic t_prescale();
        int divs[4] = '{1, 4, 16, 16};
        int n;
        for (int k = 0; k < 4; k++) begin
            wr(PMT_OFF_CONTROL, 8'h00);
            wr(PMT_OFF_PERIOD, 8'h03);
            wr(PMT_OFF_COUNT, 8'h00);
            wr(PMT_OFF_CONTROL, ctl(0, 1, k));
            wait_match(n);
            check(count, 8'h03);
            check(shift_tick, 1'b1);
            @(negedge core_clk);
            check(count, 8'h00);
            wait_match(n);
            check(n + 1, 4 * divs[k]);
            @(posedge core_clk);
        end
        wr(PMT_OFF_CONTROL, 8'h00);
    endtask

    // postscale ratio, sticky flag, masking and clearing
    task automatic t_postscale();
        int posts[3] = '{0, 1, 15};
        int m, n;
        wr(PMT_OFF_IRQ_ENABLE, 8'h02);
        wr(PMT_OFF_PERIOD, 8'h01);
        foreach (posts[i]) begin
            wr(PMT_OFF_IRQ_CLEAR, 8'h02);
            wr(PMT_OFF_COUNT, 8'h00);
            wr(PMT_OFF_CONTROL, ctl(posts[i], 1, 0));
            m = 0;
            n = 0;
            while (irq !== 1'b1) begin
                @(negedge core_clk);
                if (match === 1'b1 && irq !== 1'b1) m++;
                if (++n > 200) timed_out();
            end
            check(m, posts[i] + 1);
            @(posedge core_clk);
            wr(PMT_OFF_CONTROL, 8'h00);
        end
        wr(PMT_OFF_IRQ_ENABLE, 8'h00);
        check(irq, 1'b0);
        rd_check(PMT_OFF_IRQ_STATUS, 8'h02);
        wr(PMT_OFF_IRQ_CLEAR, 8'h02);
        rd_check(PMT_OFF_IRQ_STATUS, 8'h00);
    endtask

    // stopped count holds, control write keeps count
    task automatic t_run_hold();
        logic [31:0] d;
        logic [1:0] r;
        wr(PMT_OFF_PERIOD, 8'hFF);
        wr(PMT_OFF_CONTROL, ctl(0, 1, 0));
        repeat (5) @(posedge core_clk);
        wr(PMT_OFF_CONTROL, 8'h00);
        axi_read(PMT_OFF_COUNT, d, r);
        repeat (10) @(posedge core_clk);
        rd_check(PMT_OFF_COUNT, d[7:0]);
        wr(PMT_OFF_COUNT, 8'h42);
        wr(PMT_OFF_CONTROL, 8'h78);
        rd_check(PMT_OFF_COUNT, 8'h42);
        check(count, 8'h42);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset_values();
        t_bus_edges();
        t_prescale();
        t_postscale();
        t_run_hold();
        end_of_test();
    end
endmodule
